// >>> rtl/local_irq_pkg.sv
// Constants, encodings and types shared by the local interrupt unit.
// Assumes a single clock domain; nothing here holds state.
package local_irq_pkg;

	// ==========================================================
	// Delivery modes carried by messages and commands
	typedef enum logic [2:0] {
		DM_FIXED   = 3'h0,
		DM_LOWEST  = 3'h1,
		DM_SYSMGMT = 3'h2,
		DM_REMOTE  = 3'h3,
		DM_NMI     = 3'h4,
		DM_INIT    = 3'h5,
		DM_STARTUP = 3'h6,
		DM_EXTINT  = 3'h7
	} dmode_t;

	// ==========================================================
	// Local vector table entries, one mask and pending bit each
	localparam int NUM_LVT = 5;
	localparam int LVT_PIN0 = 0;
	localparam int LVT_PIN1 = 1;
	localparam int LVT_ERR = 2;
	localparam int LVT_PERF = 3;
	localparam int LVT_THERM = 4;
	localparam logic [NUM_LVT-1:0] MASK_ALL = 5'h1F;
	localparam logic [NUM_LVT-1:0] PEND_RESET = 5'h00;

	// ==========================================================
	// Error status bits
	localparam int ESR_W = 2;
	localparam int ESR_SEND_ILL = 0;
	localparam int ESR_RECV_ILL = 1;
	localparam logic [ESR_W-1:0] ESR_RESET = 2'h0;

	// ==========================================================
	// Identifier and destination widths
	localparam int LDR_W = 8;
	localparam int ID_W_BASE = 4;
	localparam int ID_W_LATER = 8;
	localparam logic [LDR_W-1:0] LDR_RESET = 8'h00;
	localparam logic [7:0] DEST_BCAST = 8'hFF;
	localparam logic [3:0] CLUSTER_BCAST = 4'hF;

	// Transmit state, Gray coded
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_SEND = 2'b01
	} tx_state_t;

endpackage

// >>> rtl/lint_sync.sv
// Local interrupt pin front end: synchroniser, polarity, edge pulse.
// Assumes the pin is asynchronous to mclk; polarity is a quiet level.
`timescale 1ns/1ps
module lint_sync (
	input wire logic mclk,
	input wire logic rst,
	input wire logic pin_raw,
	input wire logic active_low,
	output logic active_q,
	output logic rise_q
);
	logic meta_q;
	logic sync_q;
	logic level;

	// ==========================================================
	// Two-flop crossing; meta_q feeds sync_q and nothing else
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= pin_raw;
			sync_q <= meta_q;
		end
	end

	// Polarity applied after the crossing, never before it
	assign level = sync_q ^ active_low;

	// Active level and one-cycle pulse on its assertion
	// Reset reads as active so that an idle pin gives no false edge
	// while the crossing fills; an active-low pin that is already active at
	// reset has to go quiet once before its first edge is seen, while an active-high one gives its edge as soon as the crossing fills.
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			active_q <= 1'b1;
			rise_q <= 1'b0;
		end else begin
			active_q <= level;
			rise_q <= level & ~active_q;
		end
	end
endmodule // lint_sync

// >>> rtl/dest_match.sv
// Destination matcher for incoming messages, purely combinational.
// Assumes unit id and logical id are stable while a message is checked.
`timescale 1ns/1ps
module dest_match #(
	parameter bit LATER_GEN = 1'b0
) (
	input wire logic [7:0] dest,
	input wire logic logical,
	input wire logic cluster_mode,
	input wire logic [7:0] unit_id,
	input wire logic [local_irq_pkg::LDR_W-1:0] ldr,
	output logic hit
);
	import local_irq_pkg::*;

	localparam int ID_W = LATER_GEN ? ID_W_LATER : ID_W_BASE;

	// Cluster form: high nibble picks cluster, low nibble is a bit set
	function automatic logic cluster_hit(input logic [7:0] d,
		input logic [7:0] l);
		cluster_hit = ((d[7:4] == l[7:4]) || (d[7:4] == CLUSTER_BCAST))
			&& ((d[3:0] & l[3:0]) != 4'h0);
	endfunction

	logic phys_hit;
	logic flat_hit;

	// ==========================================================
	// id width
	assign phys_hit = (dest[ID_W-1:0] == unit_id[ID_W-1:0])
		|| (dest == DEST_BCAST);
	assign flat_hit = (dest & ldr) != 8'h00;

	// flat form dropped in later configuration
	always_comb begin
		if (!logical)
			hit = phys_hit;
		else if (cluster_mode || LATER_GEN)
			hit = cluster_hit(dest, ldr);
		else
			hit = flat_hit;
	end
endmodule // dest_match

// >>> rtl/local_irq_unit.sv
// Local interrupt unit: enable handling, local vector table masks
// and pending bits, message accept, command send, error status.
// Assumes message and command strobes come from logic on mclk and
// that the core acknowledges one pending source at a time.
// Function
// - disable keeps state, sets every mask
// - disabled unit takes only reset-type messages
// - NMI forced edge triggered, reinitialize edge except deassert
// - command messages sent edge, except deassert
// - logical destination holds eight bits
// - unit id four bits, later eight
// - later configuration refuses remote read
// - lowest priority joins only with free slot
// - cluster addressing in logical mode
// - focus checking switchable by software
// - per-pin programmable input polarity
// - system management messages sent and taken
// - error status logged and raised as interrupt
// - performance overflow has its own entry
// - thermal entry in later configuration
// - later configuration ignores focus processor
// - later configuration drops flat logical mode
`timescale 1ns/1ps
module local_irq_unit #(
	parameter bit LATER_GEN = 1'b0
) (
	input wire logic mclk,
	input wire logic rst,
	input wire logic sw_enable,
	input wire logic [local_irq_pkg::NUM_LVT-1:0] mask_set,
	input wire logic [local_irq_pkg::NUM_LVT-1:0] mask_clr,
	input wire logic pin0_raw,
	input wire logic pin1_raw,
	input wire logic pin0_active_low,
	input wire logic pin1_active_low,
	input wire logic perf_ovf,
	input wire logic thermal_evt,
	input wire logic esr_clr,
	input wire logic [7:0] unit_id,
	input wire logic ldr_wr,
	input wire logic [local_irq_pkg::LDR_W-1:0] ldr_data,
	input wire logic cluster_mode,
	input wire logic focus_chk_en,
	input wire logic focus_hit,
	input wire logic slot_free,
	input wire logic msg_valid,
	input wire local_irq_pkg::dmode_t msg_mode,
	input wire logic [7:0] msg_dest,
	input wire logic msg_logical,
	input wire logic msg_level,
	input wire logic msg_assert,
	input wire logic [7:0] msg_vector,
	input wire logic cmd_valid,
	input wire local_irq_pkg::dmode_t cmd_mode,
	input wire logic [7:0] cmd_dest,
	input wire logic cmd_logical,
	input wire logic cmd_level,
	input wire logic cmd_assert,
	input wire logic [7:0] cmd_vector,
	input wire logic tx_ack,
	input wire logic core_ack,
	output logic cmd_ready,
	output logic tx_valid_q,
	output local_irq_pkg::dmode_t tx_mode_q,
	output logic [7:0] tx_dest_q,
	output logic tx_logical_q,
	output logic tx_level_q,
	output logic tx_assert_q,
	output logic [7:0] tx_vector_q,
	output logic msg_ack_q,
	output logic msg_nak_q,
	output logic arb_join_q,
	output logic focus_claim_q,
	output logic rr_valid_q,
	output logic [7:0] rr_data_q,
	output logic deliver_q,
	output local_irq_pkg::dmode_t deliver_mode_q,
	output logic [7:0] deliver_vector_q,
	output logic deliver_edge_q,
	output logic [local_irq_pkg::NUM_LVT-1:0] mask_q,
	output logic [local_irq_pkg::NUM_LVT-1:0] pend_q,
	output logic core_irq,
	output logic [2:0] core_src,
	output logic [local_irq_pkg::ESR_W-1:0] esr_q,
	output logic [local_irq_pkg::LDR_W-1:0] ldr_q
);
	import local_irq_pkg::*;

	// Modes a disabled unit still takes
	function automatic logic reset_type(input dmode_t m);
		unique case (m)
			DM_INIT, DM_SYSMGMT, DM_NMI, DM_STARTUP: reset_type = 1'b1;
			DM_FIXED, DM_LOWEST, DM_REMOTE, DM_EXTINT: reset_type = 1'b0;
		endcase
	endfunction

	// Reinitialize deassert is the only level-type message left
	function automatic logic is_deassert(input dmode_t m,
		input logic a);
		is_deassert = (m == DM_INIT) && !a;
	endfunction

	// Lowest index pending source wins
	function automatic logic [2:0] first_set(input logic [4:0] p);
		first_set = 3'h0;
		for (int i = NUM_LVT - 1; i >= 0; i--) begin
			if (p[i])
				first_set = 3'(i);
		end
	endfunction

	logic pin0_rise;
	logic pin1_rise;
	logic dest_hit;
	logic msg_ok;
	logic esr_pulse;
	logic [NUM_LVT-1:0] evt;
	logic [NUM_LVT-1:0] ack_vec;
	logic [ESR_W-1:0] esr_set;
	tx_state_t tx_state_q;

	// ==========================================================
	// Local pins
	// polarity per pin
	lint_sync u_pin0 (
		.mclk(mclk),
		.rst(rst),
		.pin_raw(pin0_raw),
		.active_low(pin0_active_low),
		.active_q(),
		.rise_q(pin0_rise)
	);

	lint_sync u_pin1 (
		.mclk(mclk),
		.rst(rst),
		.pin_raw(pin1_raw),
		.active_low(pin1_active_low),
		.active_q(),
		.rise_q(pin1_rise)
	);

	// ==========================================================
	// Identity and destination match
	// logical id capture
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			ldr_q <= LDR_RESET;
		else if (ldr_wr)
			ldr_q <= ldr_data;
	end

	dest_match #(.LATER_GEN(LATER_GEN)) u_match (
		.dest(msg_dest),
		.logical(msg_logical),
		.cluster_mode(cluster_mode),
		.unit_id(unit_id),
		.ldr(ldr_q),
		.hit(dest_hit)
	);

	// ==========================================================
	// Masks
	// disable sets all masks
	// re-enable leaves masks set
	// Software clears act only while enabled; sets always win
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			mask_q <= MASK_ALL;
		else if (!sw_enable)
			mask_q <= MASK_ALL;
		else
			mask_q <= (mask_q & ~mask_clr) | mask_set;
	end

	// ==========================================================
	// Local sources into pending bits
	// error entry
	assign esr_pulse = |esr_set;
	assign evt = {thermal_evt & LATER_GEN, perf_ovf, esr_pulse,
		pin1_rise, pin0_rise};
	assign ack_vec = core_ack ? (5'h01 << core_src) : 5'h00;

	// Event in the ack cycle survives: set beats clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			pend_q <= PEND_RESET;
		else
			pend_q <= (pend_q & ~ack_vec) | (evt & ~mask_q);
	end

	assign core_irq = |pend_q;
	assign core_src = first_set(pend_q);

	// ==========================================================
	// Error status
	// remote read is an error in later configuration
	assign esr_set[ESR_SEND_ILL] = cmd_valid && cmd_ready
		&& LATER_GEN && (cmd_mode == DM_REMOTE);
	assign esr_set[ESR_RECV_ILL] = msg_valid && dest_hit
		&& LATER_GEN && (msg_mode == DM_REMOTE);

	// sticky log, set wins over clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			esr_q <= ESR_RESET;
		else
			esr_q <= (esr_clr ? ESR_RESET : esr_q) | esr_set;
	end

	// ==========================================================
	// Incoming messages
	// disabled unit takes only reset-type modes
	always_comb begin
		msg_ok = 1'b0;
		if (!sw_enable)
			msg_ok = reset_type(msg_mode);
		else if (msg_mode == DM_REMOTE)
			msg_ok = !LATER_GEN;
		else if (msg_mode == DM_LOWEST)
			msg_ok = slot_free;
		else
			msg_ok = 1'b1;
	end

	// Accept or refuse, one cycle after the strobe
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			msg_ack_q <= 1'b0;
			msg_nak_q <= 1'b0;
		end else begin
			msg_ack_q <= msg_valid && dest_hit && msg_ok;
			msg_nak_q <= msg_valid && dest_hit && !msg_ok;
		end
	end

	// join arbitration only with a free slot
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			arb_join_q <= 1'b0;
			focus_claim_q <= 1'b0;
		end else begin
			arb_join_q <= msg_valid && dest_hit && sw_enable
				&& (msg_mode == DM_LOWEST) && slot_free;
			focus_claim_q <= msg_valid && dest_hit && sw_enable
				&& (msg_mode == DM_LOWEST) && slot_free
				&& focus_chk_en && focus_hit && !LATER_GEN;
		end
	end

	// remote read answered only in base configuration
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rr_valid_q <= 1'b0;
			rr_data_q <= 8'h00;
		end else begin
			rr_valid_q <= msg_valid && dest_hit && sw_enable
				&& (msg_mode == DM_REMOTE) && !LATER_GEN;
			rr_data_q <= LATER_GEN ? 8'h00 : ldr_q;
		end
	end

	// Accepted messages handed to the core; remote read is not one
	// NMI forced to edge, reinitialize edge except deassert
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			deliver_q <= 1'b0;
			deliver_mode_q <= DM_FIXED;
			deliver_vector_q <= 8'h00;
			deliver_edge_q <= 1'b1;
		end else begin
			deliver_q <= msg_valid && dest_hit && msg_ok
				&& (msg_mode != DM_REMOTE);
			deliver_mode_q <= msg_mode;
			deliver_vector_q <= msg_vector;
			if (msg_mode == DM_NMI)
				deliver_edge_q <= 1'b1;
			else if (msg_mode == DM_INIT)
				deliver_edge_q <= msg_assert;
			else
				deliver_edge_q <= !msg_level;
		end
	end

	// ==========================================================
	// Command send
	// Ready only when idle: a second command waits for tx_ack
	assign cmd_ready = (tx_state_q == TX_IDLE);

	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			tx_state_q <= TX_IDLE;
		else begin
			unique case (tx_state_q)
				TX_IDLE: begin
					if (cmd_valid && !esr_set[ESR_SEND_ILL])
						tx_state_q <= TX_SEND;
				end
				TX_SEND: begin
					if (tx_ack)
						tx_state_q <= TX_IDLE;
				end
				default: tx_state_q <= TX_IDLE;
			endcase
		end
	end

	// command messages are edge, except deassert
	// system management mode may be sent
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_mode_q <= DM_FIXED;
			tx_dest_q <= 8'h00;
			tx_logical_q <= 1'b0;
			tx_level_q <= 1'b0;
			tx_assert_q <= 1'b0;
			tx_vector_q <= 8'h00;
		end else if (cmd_valid && cmd_ready) begin
			tx_mode_q <= cmd_mode;
			tx_dest_q <= cmd_dest;
			tx_logical_q <= cmd_logical;
			tx_level_q <= is_deassert(cmd_mode, cmd_assert) & cmd_level;
			tx_assert_q <= cmd_assert;
			tx_vector_q <= cmd_vector;
		end
	end

	assign tx_valid_q = (tx_state_q == TX_SEND);

	// ==========================================================
	// Checks
	// disable forces masks
	disable_mask_a: assert property (@(posedge mclk) disable iff (rst)
		!sw_enable |=> mask_q == MASK_ALL)
		else $error("masks not set while disabled");

	mask_sticky_a: assert property (@(posedge mclk) disable iff (rst)
		mask_clr == 5'h00 |=> (mask_q & $past(mask_q)) == $past(mask_q))
		else $error("mask bit dropped without clear");

	disabled_refuse_a: assert property (@(posedge mclk) disable iff (rst)
		msg_valid && !sw_enable && msg_mode == DM_FIXED
		|=> !deliver_q && !msg_ack_q)
		else $error("disabled unit took fixed message");

	nmi_edge_a: assert property (@(posedge mclk) disable iff (rst)
		deliver_q && deliver_mode_q == DM_NMI |-> deliver_edge_q)
		else $error("NMI delivered as level");

	cmd_edge_a: assert property (@(posedge mclk) disable iff (rst)
		tx_valid_q && tx_level_q |-> tx_mode_q == DM_INIT && !tx_assert_q)
		else $error("command sent level triggered");

	ldr_write_a: assert property (@(posedge mclk) disable iff (rst)
		ldr_wr |=> ldr_q == $past(ldr_data))
		else $error("logical id not captured");

	// no remote read answer in later configuration
	remote_read_a: assert property (@(posedge mclk) disable iff (rst)
		LATER_GEN && msg_valid && dest_hit && msg_mode == DM_REMOTE
		|=> !rr_valid_q && esr_q[ESR_RECV_ILL])
		else $error("remote read not refused");

	// arbitration join needs a free slot
	lowest_slot_a: assert property (@(posedge mclk) disable iff (rst)
		arb_join_q |-> $past(slot_free) && $past(msg_valid))
		else $error("joined arbitration without free slot");

	// no focus claim in later configuration
	focus_later_a: assert property (@(posedge mclk) disable iff (rst)
		LATER_GEN |-> !focus_claim_q)
		else $error("focus claimed in later configuration");

	// error event reaches pending when unmasked
	err_pend_a: assert property (@(posedge mclk) disable iff (rst)
		esr_pulse && !mask_q[LVT_ERR] |=> pend_q[LVT_ERR] && core_irq)
		else $error("error interrupt not raised");

	send_done_c: cover property (@(posedge mclk) disable iff (rst)
		cmd_valid && cmd_ready ##1 tx_valid_q [*2] ##1 !tx_valid_q);
	reenable_c: cover property (@(posedge mclk) disable iff (rst)
		!sw_enable ##1 sw_enable ##[1:20] mask_q != MASK_ALL);
	lowest_c: cover property (@(posedge mclk) disable iff (rst)
		arb_join_q ##1 deliver_q == 1'b0);
endmodule // local_irq_unit

// >>> sim/core_bus_model.sv
// Far side model: message bus acknowledge and the core taking sources.
// Assumes the unit holds tx_valid_q until acknowledged, all on mclk.
`timescale 1ns/1ps
module core_bus_model (
	input wire logic mclk,
	input wire logic rst,
	input wire logic slow,
	input wire logic take_en,
	input wire logic tx_valid_q,
	input wire logic core_irq,
	output logic tx_ack,
	output logic core_ack
);
	logic [2:0] wait_q;

	// ==========================================================
	// Bus acknowledge, prompt or after a four cycle stall
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			tx_ack <= 1'b0;
			wait_q <= 3'h0;
		end else if (tx_ack) begin
			tx_ack <= 1'b0;
			wait_q <= 3'h0;
		end else if (tx_valid_q) begin
			if (wait_q >= (slow ? 3'h4 : 3'h0))
				tx_ack <= 1'b1;
			else
				wait_q <= wait_q + 3'h1;
		end
	end

	// Core takes one source every other cycle; the gap lets the
	// pending bit clear before core_src is looked at again
	always_ff @(posedge mclk or posedge rst) begin
		if (rst)
			core_ack <= 1'b0;
		else
			core_ack <= take_en & core_irq & ~core_ack;
	end
endmodule // core_bus_model

// >>> sim/local_interrupt_unit_features_bench.sv
// Self-checking bench for the local interrupt unit: later configuration
// as dut, a base configuration unit alongside on the same stimulus.
// Assumes the core and bus model in core_bus_model on the far side.
`timescale 1ns/1ps
module local_interrupt_unit_features_bench;
	import local_irq_pkg::*;
	logic mclk, rst, sw_enable, pin0_raw, pin1_raw, pin0_active_low;
	logic pin1_active_low, perf_ovf, thermal_evt, esr_clr, ldr_wr;
	logic cluster_mode, focus_chk_en, focus_hit, slot_free, msg_valid;
	logic msg_logical, msg_level, msg_assert, cmd_valid, cmd_logical;
	logic cmd_level, cmd_assert, tx_ack, core_ack, cmd_ready, tx_valid_q;
	logic tx_logical_q, tx_level_q, tx_assert_q, msg_ack_q, msg_nak_q;
	logic arb_join_q, focus_claim_q, rr_valid_q, deliver_q, deliver_edge_q;
	logic core_irq, slow, take_en;
	logic b_ack, b_nak, b_join, b_focus, b_rr, b_del;
	logic [4:0] mask_set, mask_clr, mask_q, pend_q;
	logic [7:0] unit_id, ldr_data, msg_dest, msg_vector, cmd_dest;
	logic [7:0] cmd_vector, tx_dest_q, tx_vector_q, rr_data_q;
	logic [7:0] deliver_vector_q, ldr_q, resp, bresp, b_rr_data;
	logic [2:0] core_src;
	logic [1:0] esr_q;
	dmode_t msg_mode, cmd_mode, tx_mode_q, deliver_mode_q;
	int failures, tests_run, i;

	// ==========================================================
	// Clock, design and far side
	always #2 mclk = ~mclk;

	local_irq_unit #(.LATER_GEN(1'b1)) dut (.mclk, .rst, .sw_enable,
		.mask_set, .mask_clr, .pin0_raw, .pin1_raw, .pin0_active_low,
		.pin1_active_low, .perf_ovf, .thermal_evt, .esr_clr, .unit_id,
		.ldr_wr, .ldr_data, .cluster_mode, .focus_chk_en, .focus_hit,
		.slot_free, .msg_valid, .msg_mode, .msg_dest, .msg_logical,
		.msg_level, .msg_assert, .msg_vector, .cmd_valid, .cmd_mode,
		.cmd_dest, .cmd_logical, .cmd_level, .cmd_assert, .cmd_vector,
		.tx_ack, .core_ack, .cmd_ready, .tx_valid_q, .tx_mode_q, .tx_dest_q,
		.tx_logical_q, .tx_level_q, .tx_assert_q, .tx_vector_q, .msg_ack_q,
		.msg_nak_q, .arb_join_q, .focus_claim_q, .rr_valid_q, .rr_data_q,
		.deliver_q, .deliver_mode_q, .deliver_vector_q, .deliver_edge_q,
		.mask_q, .pend_q, .core_irq, .core_src, .esr_q, .ldr_q);

	core_bus_model far (.mclk, .rst, .slow, .take_en, .tx_valid_q,
		.core_irq, .tx_ack, .core_ack);

	// Base configuration: only its message answers are compared
	local_irq_unit #(.LATER_GEN(1'b0)) dut_base (.mclk, .rst, .sw_enable,
		.mask_set, .mask_clr, .pin0_raw, .pin1_raw, .pin0_active_low,
		.pin1_active_low, .perf_ovf, .thermal_evt, .esr_clr, .unit_id,
		.ldr_wr, .ldr_data, .cluster_mode, .focus_chk_en, .focus_hit,
		.slot_free, .msg_valid, .msg_mode, .msg_dest, .msg_logical,
		.msg_level, .msg_assert, .msg_vector, .cmd_valid, .cmd_mode,
		.cmd_dest, .cmd_logical, .cmd_level, .cmd_assert, .cmd_vector,
		.tx_ack, .core_ack, .cmd_ready(), .tx_valid_q(), .tx_mode_q(),
		.tx_dest_q(), .tx_logical_q(), .tx_level_q(), .tx_assert_q(),
		.tx_vector_q(), .msg_ack_q(b_ack), .msg_nak_q(b_nak),
		.arb_join_q(b_join), .focus_claim_q(b_focus), .rr_valid_q(b_rr),
		.rr_data_q(b_rr_data), .deliver_q(b_del), .deliver_mode_q(),
		.deliver_vector_q(), .deliver_edge_q(), .mask_q(), .pend_q(),
		.core_irq(), .core_src(), .esr_q(), .ldr_q());

	// ==========================================================
	// Compare, verdict and access tasks
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			failures++;
		end
	endtask

	task automatic give_verdict();
		if (failures == 0 && tests_run > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// One message; resp = {ack, nak, join, focus, remote, deliver}
	task automatic send_msg(input dmode_t m, input logic [7:0] d,
		input logic lg, input logic lvl, input logic asrt);
		@(posedge mclk);
		msg_valid <= 1'b1;
		msg_mode <= m;
		msg_dest <= d;
		msg_logical <= lg;
		msg_level <= lvl;
		msg_assert <= asrt;
		msg_vector <= {5'h08, m};
		@(posedge mclk);
		msg_valid <= 1'b0;
		#1 resp = {2'h0, msg_ack_q, msg_nak_q, arb_join_q, focus_claim_q,
			rr_valid_q, deliver_q};
		bresp = {2'h0, b_ack, b_nak, b_join, b_focus, b_rr, b_del};
	endtask

	// One command, strobed for one cycle, then waited out on the bus
	task automatic send_cmd(input dmode_t m, input logic lvl,
		input logic asrt);
		int n;
		logic sent;
		sent = (m != DM_REMOTE);
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_mode <= m;
		cmd_level <= lvl;
		cmd_assert <= asrt;
		cmd_vector <= {5'h0A, m};
		cmd_dest <= {5'h02, m};
		cmd_logical <= m[1];
		slow <= m[0];
		@(posedge mclk);
		cmd_valid <= 1'b0;
		#1 chk({7'h0, tx_valid_q}, {7'h0, sent});
		if (sent) begin
			chk({5'h0, tx_mode_q}, {5'h0, m});
			chk(tx_vector_q, {5'h0A, m});
			chk(tx_dest_q, {5'h02, m});
			chk({7'h0, tx_logical_q}, {7'h0, m[1]});
			chk({7'h0, tx_level_q}, {7'h0, m == DM_INIT && !asrt && lvl});
		end else begin
			@(posedge mclk);
			#1 chk({6'h0, esr_q}, 8'h01);
		end
		n = 0;
		while (tx_valid_q !== 1'b0 && n < 20) begin
			@(posedge mclk);
			#1 n++;
		end
		chk({7'h0, cmd_ready}, 8'h01);
	endtask

	// Holds for a number of cycles, then steps 1 ns past the edge so outputs have settled
	task automatic idle(input int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask

	// ==========================================================
	// Watchdog; the whole sequence needs well under 1000 cycles
	initial begin
		repeat (4000) @(posedge mclk);
		failures++;
		give_verdict();
	end

	// ==========================================================
	// Main sequence
	initial begin
		{mclk, rst, sw_enable, pin0_raw, pin0_active_low} = 5'h0F;
		{pin1_raw, pin1_active_low, perf_ovf, thermal_evt, esr_clr} = 5'h00;
		{ldr_wr, cluster_mode, msg_valid, cmd_valid, cmd_logical} = 5'h00;
		{focus_chk_en, focus_hit, slot_free, slow, take_en} = 5'h1C;
		{msg_logical, msg_level, msg_assert, cmd_level, cmd_assert} = 5'h00;
		{mask_set, mask_clr} = 10'h000;
		{unit_id, ldr_data, msg_dest, msg_vector} = 32'h05000000;
		{cmd_dest, cmd_vector} = 16'h0000;
		msg_mode = DM_FIXED;
		cmd_mode = DM_FIXED;
		failures = 0;
		tests_run = 0;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		#1 chk({3'h0, mask_q}, 8'h1F);
		@(posedge mclk);
		ldr_wr <= 1'b1;
		ldr_data <= 8'hA3;
		mask_clr <= 5'h1F;
		@(posedge mclk);
		ldr_wr <= 1'b0;
		mask_clr <= 5'h00;
		#1 chk(ldr_q, 8'hA3);
		send_msg(DM_FIXED, 8'h05, 1'b0, 1'b0, 1'b1);
		chk(resp, 8'h21);
		chk(deliver_vector_q, 8'h40);
		send_msg(DM_NMI, 8'h05, 1'b0, 1'b1, 1'b1);
		chk({7'h0, deliver_edge_q}, 8'h01);
		send_msg(DM_INIT, 8'h05, 1'b0, 1'b1, 1'b1);
		chk({7'h0, deliver_edge_q}, 8'h01);
		send_msg(DM_INIT, 8'h05, 1'b0, 1'b1, 1'b0);
		chk({7'h0, deliver_edge_q}, 8'h00);
		send_msg(DM_FIXED, 8'h15, 1'b0, 1'b0, 1'b1);
		chk(resp, 8'h00);
		chk(bresp, 8'h21);
		send_msg(DM_FIXED, 8'hA1, 1'b1, 1'b0, 1'b1);
		chk(resp, 8'h21);
		send_msg(DM_FIXED, 8'h20, 1'b1, 1'b0, 1'b1);
		chk(resp, 8'h00);
		chk(bresp, 8'h21);
		send_msg(DM_FIXED, 8'hF2, 1'b1, 1'b0, 1'b1);
		chk(resp, 8'h21);
		send_msg(DM_LOWEST, 8'h05, 1'b0, 1'b0, 1'b1);
		chk(resp, 8'h29);
		chk(bresp, 8'h2D);
		@(posedge mclk);
		slot_free <= 1'b0;
		send_msg(DM_LOWEST, 8'h05, 1'b0, 1'b0, 1'b1);
		chk(resp, 8'h10);
		chk(bresp, 8'h10);
		slot_free <= 1'b1;
		focus_chk_en <= 1'b0;
		send_msg(DM_LOWEST, 8'h05, 1'b0, 1'b0, 1'b1);
		chk(resp, 8'h29);
		chk(bresp, 8'h29);
		send_msg(DM_SYSMGMT, 8'h05, 1'b0, 1'b0, 1'b1);
		chk(resp, 8'h21);
		chk({5'h0, deliver_mode_q}, 8'h02);
		send_msg(DM_REMOTE, 8'h05, 1'b0, 1'b0, 1'b1);
		chk(resp, 8'h10);
		chk(rr_data_q, 8'h00);
		chk(bresp, 8'h22);
		chk(b_rr_data, 8'hA3);
		idle(1);
		chk({6'h0, esr_q}, 8'h02);
		idle(1);
		chk({7'h0, pend_q[LVT_ERR]}, 8'h01);
		chk({4'h0, core_irq, core_src}, 8'h0A);
		esr_clr <= 1'b1;
		take_en <= 1'b1;
		@(posedge mclk);
		esr_clr <= 1'b0;
		idle(6);
		chk({6'h0, esr_q}, 8'h00);
		chk({3'h0, pend_q}, 8'h00);
		// Disabled: masks forced, a clear attempt must not stick
		take_en <= 1'b0;
		sw_enable <= 1'b0;
		@(posedge mclk);
		mask_clr <= 5'h1F;
		@(posedge mclk);
		mask_clr <= 5'h00;
		#1 chk({3'h0, mask_q}, 8'h1F);
		chk(ldr_q, 8'hA3);
		for (i = 0; i < 8; i++) begin
			send_msg(dmode_t'(i[2:0]), 8'h05, 1'b0, 1'b0, 1'b1);
			chk({6'h0, resp[5:4]}, (i inside {2, 4, 5, 6}) ? 8'h2 : 8'h1);
		end
		sw_enable <= 1'b1;
		esr_clr <= 1'b1;
		idle(3);
		esr_clr <= 1'b0;
		chk({3'h0, mask_q}, 8'h1F);
		mask_clr <= 5'h01;
		@(posedge mclk);
		mask_clr <= 5'h1E;
		#1 chk({3'h0, mask_q}, 8'h1E);
		@(posedge mclk);
		mask_clr <= 5'h00;
		pin0_raw <= 1'b0;
		pin1_raw <= 1'b1;
		perf_ovf <= 1'b1;
		thermal_evt <= 1'b1;
		@(posedge mclk);
		perf_ovf <= 1'b0;
		thermal_evt <= 1'b0;
		idle(5);
		chk({3'h0, pend_q}, 8'h1B);
		// Swap polarities while active, so both go quiet, then assert the other way
		take_en <= 1'b1;
		pin0_active_low <= 1'b0;
		pin1_active_low <= 1'b1;
		idle(14);
		chk({3'h0, pend_q}, 8'h00);
		take_en <= 1'b0;
		pin0_raw <= 1'b1;
		pin1_raw <= 1'b0;
		idle(6);
		chk({3'h0, pend_q}, 8'h03);
		take_en <= 1'b1;
		for (i = 0; i < 8; i++)
			send_cmd(dmode_t'(i[2:0]), 1'b1, 1'b1);
		send_cmd(DM_INIT, 1'b1, 1'b0);
		give_verdict();
	end
endmodule // local_interrupt_unit_features_bench
